// [rtl/dbg_trace_cfg.svh]
`ifndef DBG_TRACE_CFG_SVH
`define DBG_TRACE_CFG_SVH
// ********************************************
// Register word offsets
// ********************************************
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h1
`define OFS_CMPA 4'h2
`define OFS_CMPB 4'h3
`define OFS_CMPC 4'h4
`define OFS_WIN 4'h5
`define OFS_CNT 4'h6
// ********************************************
// Control register fields
// ********************************************
`define CTRL_EN 15
`define CTRL_ARM 14
`define CTRL_TAG 13
`define CTRL_BEGIN 12
`define CTRL_RW_COMPARE_ENABLE_A 11
`define CTRL_RWA 10
`define CTRL_RW_COMPARE_ENABLE_B 9
`define CTRL_RWB 8
`define CTRL_BRKC 2
`define CTRL_CAPT_HI 1
`define CTRL_CAPT_LO 0
// ********************************************
// Status register fields
// ********************************************
`define STAT_FA 15
`define STAT_FB 14
`define STAT_FC 13
`define STAT_SEL_HI 3
`define STAT_SEL_LO 0
// ********************************************
// Reset values and constants
// ********************************************
`define RST_CTRL 16'h0000
`define RST_WORD 16'h0000
`define TRACE_DEPTH 64
`define TRACE_FULL 7'h40
`define INVALID_WORD 16'hFFFF
`endif

// [rtl/dbg_trace_pkg.sv]
package dbg_trace_pkg;
  // Trigger modes held in the trace content select field
  typedef enum logic [3:0] {
    TM_A_ONLY = 4'h0, TM_A_OR_B = 4'h1, TM_A_THEN_B = 4'h2,
    TM_EO_B = 4'h3, TM_A_THEN_EO_B = 4'h4, TM_A_AND_B = 4'h5,
    TM_A_NOT_B = 4'h6, TM_INSIDE = 4'h7, TM_OUTSIDE = 4'h8
  } trig_mode_t;
  // Capture modes
  typedef enum logic [1:0] {
    CM_NORMAL = 2'h0, CM_LOOP = 2'h1, CM_DETAIL = 2'h2, CM_PROFILE = 2'h3
  } capt_mode_t;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_ARMED = 3'h2, ST_FILL = 3'h4
  } seq_state_t;
  // Change-of-flow kinds reported by the core
  typedef enum logic [1:0] {
    COF_SRC = 2'h0, COF_DST = 2'h1, COF_VEC = 2'h2, COF_EXCL = 2'h3
  } cof_kind_t;
endpackage : dbg_trace_pkg

// [rtl/match_unit.sv]
`timescale 1ns/1ps
// One address/data comparator with read/write qualification
module match_unit #(
  parameter int W = 16
) (
  input wire logic cyc, // Cycle to compare is present
  input wire logic [W-1:0] value, // Bus value under test
  input wire logic [W-1:0] ref_val, // Comparator register
  input wire logic word_only, // Ignore byte bit (tagged)
  input wire logic rw_en, // Read/write qualification on
  input wire logic rw_sel, // Wanted direction, 1 = read
  input wire logic rw, // Bus direction, 1 = read
  output logic hit, // Equal and qualified
  output logic below, // value < ref_val, qualified
  output logic above // value > ref_val, qualified
);
  logic [W-1:0] v_m; // Masked value
  logic [W-1:0] r_m; // Masked reference
  logic ok; // Qualification
  // Word granularity drops bit 0 on both sides
  always_comb begin
    v_m = word_only ? {value[W-1:1], 1'b0} : value;
    r_m = word_only ? {ref_val[W-1:1], 1'b0} : ref_val;
    ok = cyc && (!rw_en || (rw_sel == rw));
    hit = ok && (v_m == r_m);
    below = ok && (v_m < r_m);
    above = ok && (v_m > r_m);
  end
endmodule : match_unit

// [rtl/trace_ram.sv]
`timescale 1ns/1ps
// Two-port trace storage, registered read
module trace_ram #(
  parameter int W = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic wr_en, // Write one word
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data // Valid the cycle after rd_addr
);
  logic [W-1:0] mem [DEPTH]; // Storage array, no reset
  // Write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // Read port, always reading
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : trace_ram

// [rtl/debug_trace_capture_buffer.sv]
`timescale 1ns/1ps
`include "dbg_trace_cfg.svh"
module debug_trace_capture_buffer
  import dbg_trace_pkg::*;
#(
  parameter int DEPTH = `TRACE_DEPTH,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic bus_valid, // One CPU bus cycle
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_rw, // 1 = read
  input wire logic bus_fetch, // Program fetch cycle
  input wire logic bus_free, // Free cycle
  input wire logic tag_valid, // Tagged opcode about to execute
  input wire logic [15:0] tag_addr,
  input wire logic cof_valid, // Change of flow reported
  input wire logic [15:0] cof_addr,
  input wire logic [1:0] cof_kind,
  input wire logic exec_valid, // Instruction executed
  input wire logic [15:0] exec_addr,
  output logic cmp_c_ignore, // C compares address only
  output logic cmp_c_brk_en // C breakpoints allowed
);
  // ********************************************
  // Register state
  // ********************************************
  logic [15:0] ctrl_q; // Control bits, arm kept in state
  logic [3:0] sel_q; // trace_content_select
  logic [15:0] cmpa_q; // Comparator A
  logic [15:0] cmpb_q; // Comparator B
  logic [15:0] cmpc_q; // Comparator C
  logic fa_q, fb_q, fc_q; // Match flags
  seq_state_t st_q; // Sequencer
  logic seen_a_q; // A seen in sequential modes
  logic [6:0] cnt_q; // valid_word_count
  logic [AW-1:0] wp_q; // Write pointer
  logic [AW-1:0] ofs_q; // Read offset from oldest word
  logic pend_q; // Detail data word waiting
  logic [15:0] pend_d_q; // Detail data to write
  logic [15:0] last_exec_q; // Last executed address
  logic [15:0] rdata_q; // Read data other than RAM words
  logic win_q; // Last read was a good window read
  logic [15:0] ram_q; // RAM read data
  logic en, tag, begin_bit, ctrl_wr, arm_req;
  trig_mode_t tm;
  capt_mode_t cm;
  always_comb begin
    en = ctrl_q[`CTRL_EN];
    tag = ctrl_q[`CTRL_TAG];
    begin_bit = ctrl_q[`CTRL_BEGIN];
    tm = trig_mode_t'(sel_q);
    cm = capt_mode_t'(ctrl_q[`CTRL_CAPT_HI:`CTRL_CAPT_LO]);
    ctrl_wr = reg_wr && (reg_addr == `OFS_CTRL);
    // Profile never arms
    arm_req = ctrl_wr && reg_wdata[`CTRL_ARM] && reg_wdata[`CTRL_EN]
      && (reg_wdata[`CTRL_CAPT_HI:`CTRL_CAPT_LO] != CM_PROFILE);
  end
  // ********************************************
  // Mode conflict resolution
  // ********************************************
  logic detail, eo_mode, eo_live, begin_eff, full_mode, tag_a, tag_b;
  always_comb begin
    detail = (cm == CM_DETAIL);
    eo_mode = (tm == TM_EO_B) || (tm == TM_A_THEN_EO_B);
    eo_live = eo_mode && !detail;
    begin_eff = begin_bit || eo_live;
    full_mode = (tm == TM_A_AND_B) || (tm == TM_A_NOT_B);
    tag_a = tag && !(tm == TM_EO_B && !detail);
    tag_b = tag && !eo_live;
  end
  // ********************************************
  // Comparators
  // ********************************************
  logic hit_a, lt_a, gt_a, hit_b, lt_b, gt_b, hit_d;
  logic range_m;
  // Ranges run on A's source so both limits see one address
  assign range_m = (tm == TM_INSIDE) || (tm == TM_OUTSIDE);
  // Tagged compares use opcode tags, forced ones the bus; RW off when tagged
  match_unit #(.W(16)) u_cmp_a (
    .cyc(tag_a ? tag_valid : bus_valid),
    .value(tag_a ? tag_addr : bus_addr),
    .ref_val(cmpa_q),
    .word_only(tag_a && range_m),
    .rw_en(ctrl_q[`CTRL_RW_COMPARE_ENABLE_A] && !tag_a),
    .rw_sel(ctrl_q[`CTRL_RWA]),
    .rw(bus_rw),
    .hit(hit_a),
    .below(lt_a),
    .above(gt_a)
  );
  // Forced ranges compare the full byte access address as issued
  match_unit #(.W(16)) u_cmp_b (
    .cyc((tag_b && range_m) ? tag_valid : (tag_b ? tag_valid : bus_valid)),
    .value(tag_b ? tag_addr : bus_addr),
    .ref_val(cmpb_q),
    .word_only(tag_b && range_m),
    .rw_en(ctrl_q[`CTRL_RW_COMPARE_ENABLE_B] && !tag_b),
    .rw_sel(ctrl_q[`CTRL_RWB]),
    .rw(bus_rw),
    .hit(hit_b),
    .below(lt_b),
    .above(gt_b)
  );
  // Full modes: B watches the data bus, qualified by A's RW bits
  assign hit_d = bus_valid && (bus_data == cmpb_q)
    && (!ctrl_q[`CTRL_RW_COMPARE_ENABLE_A] || (ctrl_q[`CTRL_RWA] == bus_rw));
  // ********************************************
  // Trigger decode
  // ********************************************
  logic trig, set_a, set_b, in_a, in_b;
  always_comb begin
    trig = 1'b0;
    set_a = 1'b0;
    set_b = 1'b0;
    // Built from qualified compares so a refused direction never counts as in range
    in_a = hit_a || gt_a;
    in_b = hit_b || lt_b;
    case (tm)
      TM_A_ONLY: begin
        set_a = hit_a;
        trig = hit_a;
      end
      TM_A_OR_B: begin
        set_a = hit_a;
        set_b = hit_b;
        trig = hit_a || hit_b;
      end
      TM_A_THEN_B, TM_A_THEN_EO_B: begin
        set_a = hit_a;
        set_b = hit_b && seen_a_q;
        trig = hit_b && seen_a_q;
      end
      TM_EO_B: begin
        set_b = hit_b;
        trig = hit_b;
      end
      TM_A_AND_B, TM_A_NOT_B: begin
        // Tagged full modes reduce to A only
        trig = tag ? hit_a : hit_a && ((tm == TM_A_AND_B) == hit_d);
        set_a = trig;
        set_b = trig && !tag;
      end
      TM_INSIDE: begin
        trig = in_a && in_b;
        set_a = trig;
        set_b = trig;
      end
      TM_OUTSIDE: begin
        set_a = lt_a;
        set_b = gt_b;
        trig = lt_a || gt_b;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
  end
  // ********************************************
  // Store selection
  // ********************************************
  logic armed, live, may_store, loop_sup, c_hit, new_ok, wr_en;
  logic [15:0] new_w, wr_w;
  always_comb begin
    armed = (st_q != ST_IDLE);
    live = armed && (cm != CM_PROFILE);
    // End type skips the trigger cycle, begin type keeps it
    may_store = live && ((st_q == ST_FILL)
      || (begin_eff ? trig : !trig));
    c_hit = cof_valid && (cof_addr == cmpc_q) && cmp_c_ignore;
    // Only sources are filtered, plain CPU address, no page
    loop_sup = (cm == CM_LOOP) && (cof_kind == COF_SRC) && c_hit;
    new_w = cof_addr;
    new_ok = cof_valid && (cof_kind != COF_EXCL) && !loop_sup;
    if (detail) begin
      new_w = bus_addr;
      new_ok = bus_valid && !bus_fetch && !bus_free;
    end else if (eo_live) begin
      new_w = bus_data;
      new_ok = trig && hit_b;
    end
    // A pending data word wins; a colliding detail cycle is lost
    wr_en = pend_q || (may_store && new_ok);
    wr_w = pend_q ? pend_d_q : new_w;
  end
  // ********************************************
  // Control and comparator registers
  // ********************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `RST_CTRL;
      sel_q <= 4'h0;
      cmpa_q <= `RST_WORD;
      cmpb_q <= `RST_WORD;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CTRL: ctrl_q <= reg_wdata & ~(16'h1 << `CTRL_ARM);
        `OFS_STAT: sel_q <= reg_wdata[`STAT_SEL_HI:`STAT_SEL_LO];
        `OFS_CMPA: cmpa_q <= reg_wdata;
        `OFS_CMPB: cmpb_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end
  // Comparator C: software value, or loop mode self-load
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmpc_q <= `RST_WORD;
      cmp_c_ignore <= 1'b0;
    end else if (arm_req && reg_wdata[`CTRL_CAPT_HI:`CTRL_CAPT_LO] == CM_LOOP) begin
      cmpc_q <= `RST_WORD;
      cmp_c_ignore <= 1'b0;
    end else if (cm == CM_LOOP && wr_en && !pend_q && !detail && !eo_live) begin
      cmpc_q <= wr_w;
      cmp_c_ignore <= 1'b1;
    end else if (reg_wr && reg_addr == `OFS_CMPC) begin
      cmpc_q <= reg_wdata;
      cmp_c_ignore <= 1'b0;
    end
  end
  // C breakpoints are blocked in loop and profile modes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_c_brk_en <= 1'b0;
    end else begin
      cmp_c_brk_en <= ctrl_q[`CTRL_BRKC] && en
        && (cm != CM_LOOP) && (cm != CM_PROFILE);
    end
  end
  // ********************************************
  // Flags and sequencer
  // ********************************************
  // Arming clears flags; while armed, matches set them, C's only outside loop mode
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fa_q <= 1'b0;
      fb_q <= 1'b0;
      fc_q <= 1'b0;
    end else if (arm_req) begin
      fa_q <= 1'b0;
      fb_q <= 1'b0;
      fc_q <= 1'b0;
    end else if (live) begin
      fa_q <= fa_q || set_a;
      fb_q <= fb_q || set_b;
      fc_q <= fc_q || (bus_valid && bus_addr == cmpc_q && cm != CM_LOOP);
    end
  end
  // Arm, trigger, fill and disarm
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      seen_a_q <= 1'b0;
    end else if (arm_req) begin
      st_q <= ST_ARMED;
      seen_a_q <= 1'b0;
    end else if (ctrl_wr || !en || cm == CM_PROFILE) begin
      st_q <= ST_IDLE; // Disarm by software
    end else begin
      seen_a_q <= seen_a_q || (live && hit_a);
      case (st_q)
        ST_ARMED: begin
          if (trig) begin
            st_q <= begin_eff ? ST_FILL : ST_IDLE;
          end
        end
        ST_FILL: begin
          if (wr_en && cnt_q == `TRACE_FULL - 7'h1) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // ********************************************
  // Trace storage
  // ********************************************
  logic stop_now;
  assign stop_now = (st_q == ST_FILL) && (cnt_q == `TRACE_FULL - 7'h1);
  // Write pointer wraps; count saturates at the depth
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      cnt_q <= 7'h0;
      pend_q <= 1'b0;
      pend_d_q <= `RST_WORD;
    end else if (arm_req) begin
      wp_q <= '0;
      cnt_q <= 7'h0;
      pend_q <= 1'b0;
    end else if (wr_en) begin
      wp_q <= wp_q + 1'b1;
      cnt_q <= (cnt_q == `TRACE_FULL) ? cnt_q : cnt_q + 7'h1;
      // Address goes first, data next cycle
      pend_q <= !pend_q && detail && !stop_now && live;
      pend_d_q <= bus_data;
    end else begin
      pend_q <= 1'b0;
    end
  end
  // ********************************************
  // Register read side
  // ********************************************
  logic win_rd, win_ok;
  logic [AW-1:0] rd_ptr;
  always_comb begin
    win_rd = reg_rd && (reg_addr == `OFS_WIN);
    win_ok = en && !armed;
    // Oldest word sits count places behind the write pointer
    rd_ptr = wp_q - cnt_q[AW-1:0] + ofs_q;
  end
  // Read pointer moves only on good window reads
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ofs_q <= '0;
    end else if (arm_req) begin
      ofs_q <= '0;
    end else if (win_rd && win_ok && cm != CM_PROFILE) begin
      ofs_q <= ofs_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_exec_q <= `RST_WORD;
    end else if (exec_valid) begin
      last_exec_q <= exec_addr;
    end
  end
  trace_ram #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .ref_clk(ref_clk),
    .wr_en(wr_en),
    .wr_addr(wp_q),
    .wr_data(wr_w),
    .rd_addr(rd_ptr),
    .rd_data(ram_q)
  );
  // Read data registered; RAM word muxed in the following cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= `RST_WORD;
      win_q <= 1'b0;
    end else begin
      win_q <= win_rd && win_ok && cm != CM_PROFILE;
      case (reg_addr)
        `OFS_CTRL: rdata_q <= ctrl_q | ({15'h0, armed} << `CTRL_ARM);
        `OFS_STAT: rdata_q <= {fa_q, fb_q, fc_q, 9'h0, sel_q};
        `OFS_CMPA: rdata_q <= cmpa_q;
        `OFS_CMPB: rdata_q <= cmpb_q;
        `OFS_CMPC: rdata_q <= cmpc_q;
        `OFS_CNT: rdata_q <= {9'h0, cnt_q};
        `OFS_WIN: rdata_q <= (cm == CM_PROFILE) ? last_exec_q
          : (win_ok ? `RST_WORD : `INVALID_WORD);
        default: rdata_q <= `RST_WORD;
      endcase
    end
  end
  assign reg_rdata = win_q ? ram_q : rdata_q;
  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_arm_clears_flags: assert property (arm_req |=> !fa_q && !fb_q && !fc_q)
    else $error("arming left a match flag set");
  a_inside_both_flags: assert property (
    live && tm == TM_INSIDE && !ctrl_wr && (in_a != in_b) && !fa_q && !fb_q
    |=> !fa_q && !fb_q)
    else $error("one-sided inside match set a flag");
  a_outside_flag_a: assert property (
    live && tm == TM_OUTSIDE && lt_a && !ctrl_wr |=> fa_q)
    else $error("outside match below A left flag clear");
  a_end_trig_stop: assert property (
    st_q == ST_ARMED && !begin_eff && trig && !reg_wr && en && live
    |=> st_q == ST_IDLE && $stable(cnt_q))
    else $error("end trigger did not stop without storing");
  a_begin_full_stop: assert property (
    st_q == ST_FILL && wr_en && cnt_q == 7'h3F && !reg_wr && en
    |=> st_q == ST_IDLE && cnt_q == 7'h40)
    else $error("begin trigger did not stop at 64 words");
  a_armed_read_bad: assert property (
    win_rd && armed && cm != CM_PROFILE |=> reg_rdata == `INVALID_WORD && $stable(ofs_q))
    else $error("armed window read was not invalid");
  a_loop_c_copy: assert property (
    cm == CM_LOOP && wr_en && !pend_q && !eo_live && !arm_req
    |=> cmpc_q == $past(wr_w) && cmp_c_ignore)
    else $error("loop mode did not load comparator C");
  a_detail_data_next: assert property (
    detail && wr_en && !pend_q && !stop_now && !arm_req
    |=> wr_en && wr_w == $past(bus_data))
    else $error("detail data did not follow address");
  a_profile_no_count: assert property (
    cm == CM_PROFILE && !arm_req |=> $stable(cnt_q))
    else $error("profile mode changed the count");
  c_begin_fill: cover property (st_q == ST_FILL ##[1:200] st_q == ST_IDLE);
  c_end_trigger: cover property (st_q == ST_ARMED && trig && !begin_eff);
  c_loop_suppress: cover property (live && loop_sup);
  c_fifo_read: cover property (win_rd && win_ok && cnt_q != 7'h0);
endmodule : debug_trace_capture_buffer

// [tb/cpu_core_model.sv]
`timescale 1ns/1ps
// ****************************************
// Core stand-in: flow, bus and execute events
// ****************************************
module cpu_core_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ev_req, // One event wanted
  input wire logic [2:0] ev_sel, // Bit0 flow, bit1 bus, bit2 execute
  input wire logic [15:0] ev_a,
  input wire logic [15:0] ev_d,
  input wire logic [1:0] ev_k,
  input wire logic ev_f, // Event is a program fetch
  output logic cof_valid,
  output logic bus_valid,
  output logic exec_valid,
  output logic [15:0] ev_addr, // Shared by flow, bus and execute
  output logic [15:0] bus_data,
  output logic [1:0] cof_kind,
  output logic bus_fetch,
  output logic bus_rw,
  output logic bus_free
);
  // Reads only and no free cycles in this model
  assign bus_rw = 1'b1;
  assign bus_free = 1'b0;
  // Events last one cycle; idle address and data lines flip so stale values never pass
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {exec_valid, bus_valid, cof_valid} <= 3'h0;
      ev_addr <= 16'h0000;
      bus_data <= 16'h0000;
      cof_kind <= 2'h0;
      bus_fetch <= 1'b0;
    end else begin
      {exec_valid, bus_valid, cof_valid} <= ev_req ? ev_sel : 3'h0;
      ev_addr <= ev_req ? ev_a : ~ev_addr;
      bus_data <= ev_req ? ev_d : ~bus_data;
      cof_kind <= ev_k;
      bus_fetch <= ev_req & ev_f;
    end
  end
endmodule : cpu_core_model

// [tb/debug_trace_capture_buffer_tb.sv]
`timescale 1ns/1ps
`include "dbg_trace_cfg.svh"
module debug_trace_capture_buffer_tb
  import dbg_trace_pkg::*;
;
  localparam logic [15:0] EN_ARM = 16'hC000; // Enable and arm
  logic ref_clk, sys_rst, reg_wr, reg_rd, ev_req, ev_f;
  logic cof_valid, bus_valid, exec_valid, bus_fetch, bus_rw, bus_free;
  logic cmp_c_ignore, cmp_c_brk_en;
  logic [3:0] reg_addr;
  logic [2:0] ev_sel;
  logic [1:0] ev_k, cof_kind;
  logic [15:0] reg_wdata, reg_rdata, ev_a, ev_d, ev_addr, bus_data, d, t, c;
  logic [15:0] q[$];
  int num_errors, compares, i;
  debug_trace_capture_buffer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_valid(bus_valid), .bus_addr(ev_addr), .bus_data(bus_data), .bus_rw(bus_rw),
    .bus_fetch(bus_fetch), .bus_free(bus_free), .tag_valid(bus_valid), .tag_addr(ev_addr),
    .cof_valid(cof_valid), .cof_addr(ev_addr), .cof_kind(cof_kind),
    .exec_valid(exec_valid), .exec_addr(ev_addr), .cmp_c_ignore(cmp_c_ignore),
    .cmp_c_brk_en(cmp_c_brk_en));
  cpu_core_model core (.ref_clk(ref_clk), .sys_rst(sys_rst), .ev_req(ev_req),
    .ev_sel(ev_sel), .ev_a(ev_a), .ev_d(ev_d), .ev_k(ev_k), .ev_f(ev_f),
    .cof_valid(cof_valid), .bus_valid(bus_valid), .exec_valid(exec_valid),
    .ev_addr(ev_addr), .bus_data(bus_data), .cof_kind(cof_kind), .bus_fetch(bus_fetch),
    .bus_rw(bus_rw), .bus_free(bus_free));
  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task ev(input logic [2:0] s, input logic [15:0] a, input logic [1:0] k,
      input logic [15:0] dd, input logic f);
    @(posedge ref_clk);
    {ev_req, ev_sel, ev_a, ev_k, ev_d, ev_f} <= {1'b1, s, a, k, dd, f};
    @(posedge ref_clk);
    ev_req <= 1'b0;
  endtask : ev
  // Reads every expected word oldest first, count must not move
  task drain(input string n);
    rd(`OFS_CNT);
    c = d;
    foreach (q[j]) begin
      rd(`OFS_WIN);
      chk(n, q[j], d);
    end
    rd(`OFS_CNT);
    chk("cnt_kept", c, d);
  endtask : drain
  task rng(input logic [15:0] m, input logic [15:0] miss, input logic [15:0] hit,
      input logic [15:0] fl, input logic [15:0] cv);
    wr(`OFS_STAT, m);
    wr(`OFS_CMPA, 16'h1000);
    wr(`OFS_CMPB, 16'h2000);
    wr(`OFS_CTRL, cv);
    ev(3'h2, miss, 2'h0, 16'h0000, 1'b0);
    rd(`OFS_CTRL);
    chk("rng_armed", 16'h4000, d & 16'h4000);
    ev(3'h2, hit, 2'h0, 16'h0000, 1'b0);
    rd(`OFS_STAT);
    chk("rng_flags", fl, d & 16'hE000);
    rd(`OFS_CTRL);
    chk("rng_disarm", 16'h0000, d & 16'h4000);
  endtask : rng
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {sys_rst, reg_wr, reg_rd, ev_req, ev_f} = 5'h10;
    {reg_addr, reg_wdata, ev_sel, ev_a, ev_d, ev_k} = '0;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'h341B));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`OFS_CTRL);
    chk("ctrl_rst", `RST_CTRL, d);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk("unmapped", 16'h0000, d);
    rng(16'(TM_INSIDE), 16'h0800, 16'h1800, 16'hC000, EN_ARM);
    rng(16'(TM_OUTSIDE), 16'h1800, 16'h2802, 16'h4000, EN_ARM);
    rng(16'(TM_OUTSIDE), 16'h2000, 16'h0FFE, 16'h8000, EN_ARM);
    // Tagged range: write-only qualifier ignored, limits judged per word
    rng(16'(TM_INSIDE), 16'h0FFF, 16'h2001, 16'hC000, EN_ARM | 16'h2800);
    // End-trigger in normal capture: trigger flow is dropped
    t = 16'h4000;
    wr(`OFS_STAT, 16'(TM_A_ONLY));
    wr(`OFS_CMPA, t);
    wr(`OFS_CTRL, EN_ARM);
    rd(`OFS_WIN);
    chk("win_armed", `INVALID_WORD, d);
    q = {};
    for (i = 0; i < 5; i++) begin
      q.push_back(16'($urandom));
      ev(3'h1, q[i], COF_SRC, 16'h0000, 1'b0);
    end
    ev(3'h1, 16'h7777, COF_EXCL, 16'h0000, 1'b0);
    ev(3'h3, t, COF_SRC, 16'h0000, 1'b0);
    rd(`OFS_CNT);
    chk("cnt_end", 16'h0005, d & 16'h007F);
    drain("end_word");
    // Begin-trigger: nothing before, trigger flow kept, stop at full
    wr(`OFS_CTRL, EN_ARM | 16'h1000);
    rd(`OFS_STAT);
    chk("flags_clr", 16'h0000, d & 16'hE000);
    ev(3'h1, 16'h0F0F, COF_DST, 16'h0000, 1'b0);
    q = {t};
    ev(3'h3, t, COF_SRC, 16'h0000, 1'b0);
    for (i = 0; i < 70; i++) begin
      d = 16'($urandom);
      if (q.size() < `TRACE_DEPTH) q.push_back(d);
      ev(3'h1, d, COF_VEC, 16'h0000, 1'b0);
    end
    rd(`OFS_CNT);
    chk("cnt_full", 16'(`TRACE_FULL), d & 16'h007F);
    drain("begin_word");
    // Loop capture: repeated sources dropped, repeated destinations kept
    wr(`OFS_CTRL, EN_ARM | 16'h0005);
    rd(`OFS_CTRL);
    chk("c_ignore_arm", 16'h0000, {15'h0, cmp_c_ignore});
    chk("c_brk_loop", 16'h0000, {15'h0, cmp_c_brk_en});
    ev(3'h1, 16'h1111, COF_SRC, 16'h0000, 1'b0);
    ev(3'h1, 16'h1111, COF_SRC, 16'h0000, 1'b0);
    rd(`OFS_CTRL);
    chk("c_ignore", 16'h0001, {15'h0, cmp_c_ignore});
    ev(3'h1, 16'h2222, COF_DST, 16'h0000, 1'b0);
    ev(3'h1, 16'h2222, COF_DST, 16'h0000, 1'b0);
    ev(3'h2, t, 2'h0, 16'h0000, 1'b0);
    q = {16'h1111, 16'h2222, 16'h2222};
    drain("loop_word");
    // Detail capture: address then data, fetch cycles skipped
    wr(`OFS_CTRL, EN_ARM | 16'h0006);
    ev(3'h2, 16'h0100, 2'h0, 16'hA5A5, 1'b0);
    chk("c_brk_on", 16'h0001, {15'h0, cmp_c_brk_en});
    ev(3'h2, 16'h0200, 2'h0, 16'h5A5A, 1'b1);
    ev(3'h2, 16'h0300, 2'h0, 16'h3C3C, 1'b0);
    ev(3'h2, t, 2'h0, 16'h0000, 1'b0);
    q = {16'h0100, 16'hA5A5, 16'h0300, 16'h3C3C};
    drain("detail_word");
    // Profile: window shows last executed address, count frozen
    wr(`OFS_CTRL, 16'h8003);
    rd(`OFS_CNT);
    c = d;
    for (i = 0; i < 3; i++) begin
      t = 16'($urandom);
      ev(3'h4, t, 2'h0, 16'h0000, 1'b0);
      rd(`OFS_WIN);
      chk("profile", t, d);
      rd(`OFS_WIN);
      chk("profile_again", t, d);
    end
    rd(`OFS_CNT);
    chk("profile_cnt", c, d);
    end_of_test();
  end
  // Whole run is well under a thousand cycles; this is ample
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end
endmodule : debug_trace_capture_buffer_tb
